/* File: core/asc_pkg.sv */
// Register map, field positions, timing counts and carrier types of the serial control block.
package asc_pkg;
	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h04;
	localparam logic [7:0] ADDR_CTRL3 = 8'h08;
	localparam logic [7:0] ADDR_STAT1 = 8'h0c;
	localparam logic [7:0] ADDR_DATA  = 8'h10;
	// First control register fields.
	localparam int         C1_MODULE_ON  = 6;
	localparam int         C1_NINE_BIT   = 4;
	localparam int         C1_WAKE_ADDR  = 3;
	localparam int         C1_PARITY_EN  = 1;
	localparam int         C1_PARITY_ODD = 0;
	localparam logic [7:0] C1_WMASK      = 8'h5b;
	// Second control register fields.
	localparam int C2_TXBUF_IRQ_EN  = 7;
	localparam int C2_TXDONE_IRQ_EN = 6;
	localparam int C2_RXFULL_IRQ_EN = 5;
	localparam int C2_QUIET_IRQ_EN  = 4;
	localparam int C2_XMIT_ON       = 3;
	localparam int C2_RX_ON         = 2;
	localparam int C2_RX_STANDBY    = 1;
	localparam int C2_BREAK_SEND    = 0;
	// Third control register fields; bits 3:0 enable the error requests of the matching status bits.
	localparam int         C3_RX_NINTH = 7;
	localparam int         C3_TX_NINTH = 6;
	localparam logic [7:0] C3_WMASK    = 8'h4f;
	// First status register fields.
	localparam int S_EMPTY   = 7;
	localparam int S_DONE    = 6;
	localparam int S_FULL    = 5;
	localparam int S_QUIET   = 4;
	localparam int S_OVERRUN = 3;
	localparam int S_NOISE   = 2;
	localparam int S_FRAMING = 1;
	localparam int S_PARITY  = 0;
	// Values after reset.
	localparam logic [7:0] C1_RST = 8'h00;
	localparam logic [7:0] C2_RST = 8'h00;
	localparam logic [7:0] C3_RST = 8'h00;
	localparam logic [7:0] S1_RST = 8'hc0;
	// Bit timing in core clock cycles, and character lengths in bits.
	localparam logic [3:0] BIT_LAST  = 4'hf;
	localparam logic [3:0] HALF_LAST = 4'h7;
	localparam logic [3:0] NOISE_AT  = 4'he;
	localparam logic [3:0] LEN_EIGHT = 4'ha;
	localparam logic [3:0] LEN_NINE  = 4'hb;

	typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_DATA, TX_BRK, TX_MARK} asc_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asc_rx_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} asc_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} asc_apb_rsp_s;

	typedef struct packed {
		logic [7:0]   c1;
		logic [7:0]   c2;
		logic [7:0]   c3;
		logic [7:0]   flags;
		logic [7:0]   txData;
		logic [7:0]   rxData;
		logic         rxNinth;
		logic         emptyArm;
		logic [5:0]   rxArm;
		asc_tx_e      txSt;
		logic [10:0]  txSh;
		logic [3:0]   txBits;
		logic [3:0]   txDiv;
		logic         pendPre;
		logic         brkReq;
		asc_rx_e      rxSt;
		logic [3:0]   rxCnt;
		logic [3:0]   rxBits;
		logic [3:0]   ones;
		logic [8:0]   rxSh;
		logic         rxPrev;
		logic         noiseHit;
		logic         idleArm;
		logic         txd;
		logic         irqTx;
		logic         irqRx;
		logic         irqErr;
		asc_apb_rsp_s rsp;
	} asc_state_s;
endpackage

/* File: core/asc_serial_ctrl.sv */
// Serial port control, transmitter, receiver and status flags behind an APB slave.
// Operation
// - Empty-buffer request only when its enable set.
// - Done request only when its enable set.
// - Receive-full request only when enable set.
// - Quiet-line request only when enable set.
// - Enabling transmitter sends ten or eleven ones.
// - Disabling transmitter finishes current character first.
// - Off-on during character queues one idle character.
// - Receiver disable keeps all receive flags.
// - Standby suppresses every receiver request.
// - Quiet line or address mark ends standby.
// - Break pulse sends one break, one high.
// - Held break sends breaks back to back.
// - Early break replaces the pending preamble.
// - Nine-bit mode captures ninth bit with data.
// - Eight-bit mode ninth bit copies bit seven.
// - Transmit ninth bit loads with the data.
// - Overrun request only when its enable set.
// - Noise, framing, parity requests separately enabled.
// - Empty flag sets when buffer feeds shifter.
// - Empty clears after status read, data write.
// - Module off sets empty, done, blocks transmit requests.
// - Done flag: empty, shifter idle, nothing queued.
// - Width bit selects eight or nine bits.
`timescale 1ns/1ps
module asc_serial_ctrl
	import asc_pkg::*;
(
	// Clock and reset.
	input  logic         core_clk,
	input  logic         rst,
	// Register bus.
	input  asc_apb_req_s apbReq,
	output asc_apb_rsp_s apbRsp,
	// Serial lines.
	input  logic         rxd,
	output logic         txd,
	// Interrupt requests.
	output logic         irqTx,
	output logic         irqRx,
	output logic         irqErr
);
	asc_state_s s;
	asc_state_s n;
	logic       apbSetup;
	logic       apbAccess;
	logic       nine;
	logic [3:0] charLen;

	// Picks the next character: break, then preamble, then buffered data.
	function automatic asc_state_s txPick(input asc_state_s t, input logic [3:0] len,
		input logic isNine);
		asc_state_s r;
		r = t;
		r.txSt = TX_IDLE;
		r.txSh = 11'h7ff;
		r.txBits = 4'h0;
		if (!t.c2[C2_XMIT_ON]) begin
			r.txSt = TX_IDLE;
		end else if (t.brkReq || t.c2[C2_BREAK_SEND]) begin
			r.txSt = TX_BRK;
			r.txSh = 11'h000;
			r.txBits = len;
			r.brkReq = 1'b0;
			r.pendPre = 1'b0;
		end else if (t.pendPre) begin
			r.txSt = TX_PRE;
			r.txBits = len;
			r.pendPre = 1'b0;
		end else if (!t.flags[S_EMPTY]) begin
			r.txSt = TX_DATA;
			r.txBits = len;
			if (isNine) begin
				r.txSh = {1'b1, t.c3[C3_TX_NINTH], t.txData, 1'b0};
			end else begin
				r.txSh = {2'b11, t.txData, 1'b0};
			end
			r.flags[S_EMPTY] = 1'b1;
		end
		r.txd = r.txSh[0];
		return r;
	endfunction

	// Bus phases and the character width.
	assign apbSetup = apbReq.psel && !apbReq.penable;
	assign apbAccess = apbReq.psel && apbReq.penable && s.rsp.pready;
	assign nine = s.c1[C1_NINE_BIT];
	assign charLen = nine ? LEN_NINE : LEN_EIGHT;

	// Next state: bus effects first, then hardware sets, so a set wins over a clear.
	always_comb begin
		logic [7:0] rd;
		logic [7:0] wv;
		logic [8:0] d9;
		logic       msb;
		logic       hit;
		logic       tick;
		rd = 8'h00;
		wv = apbReq.pwdata[7:0];
		d9 = nine ? s.rxSh : {1'b0, s.rxSh[8:1]};
		msb = nine ? d9[8] : d9[7];
		hit = s.noiseHit || (rxd != s.rxPrev);
		tick = (s.txDiv == BIT_LAST);
		n = s;

		// Answer every access phase in its first cycle; read data is taken at setup.
		n.rsp.pready = apbSetup;
		if (apbSetup) begin
			n.rsp.pslverr = 1'b0;
			if (apbReq.paddr == ADDR_CTRL1) begin
				rd = s.c1;
			end else if (apbReq.paddr == ADDR_CTRL2) begin
				rd = s.c2;
			end else if (apbReq.paddr == ADDR_CTRL3) begin
				rd = {s.rxNinth, s.c3[6:0]};
			end else if (apbReq.paddr == ADDR_STAT1) begin
				rd = s.flags;
			end else if (apbReq.paddr == ADDR_DATA) begin
				rd = s.rxData;
			end else begin
				n.rsp.pslverr = 1'b1;
			end
			n.rsp.prdata = {24'h000000, rd};
		end

		// Register writes and the side effects of reads.
		if (apbAccess && apbReq.pwrite && !s.rsp.pslverr) begin
			if (apbReq.paddr == ADDR_CTRL1) begin
				n.c1 = wv & C1_WMASK;
			end else if (apbReq.paddr == ADDR_CTRL2) begin
				if (!s.c1[C1_MODULE_ON]) begin
					wv[C2_XMIT_ON] = s.c2[C2_XMIT_ON];
					wv[C2_RX_ON] = s.c2[C2_RX_ON];
				end
				if (wv[C2_XMIT_ON] && !s.c2[C2_XMIT_ON]) begin
					n.pendPre = 1'b1;
				end
				if (wv[C2_BREAK_SEND] && !s.c2[C2_BREAK_SEND]) begin
					n.brkReq = 1'b1;
				end
				n.c2 = wv;
			end else if (apbReq.paddr == ADDR_CTRL3) begin
				n.c3 = wv & C3_WMASK;
			end else if (apbReq.paddr == ADDR_DATA) begin
				n.txData = wv;
				if (s.emptyArm) begin
					n.flags[S_EMPTY] = 1'b0;
					n.emptyArm = 1'b0;
				end
			end
		end else if (apbAccess && !s.rsp.pslverr) begin
			if (apbReq.paddr == ADDR_STAT1) begin
				n.emptyArm = s.rsp.prdata[S_EMPTY];
				n.rxArm = s.rsp.prdata[5:0];
			end else if (apbReq.paddr == ADDR_DATA) begin
				n.flags = s.flags & ~{2'b00, s.rxArm};
				n.rxArm = 6'h00;
			end
		end

		// Transmitter, advanced once per bit period.
		n.txDiv = s.c1[C1_MODULE_ON] ? s.txDiv + 4'h1 : 4'h0;
		if (tick) begin
			if (n.txSt == TX_IDLE) begin
				n = txPick(n, charLen, nine);
			end else if (n.txBits > 4'h1) begin
				n.txSh = {1'b1, n.txSh[10:1]};
				n.txBits = n.txBits - 4'h1;
				n.txd = n.txSh[0];
			end else if (n.txSt == TX_BRK && !n.c2[C2_BREAK_SEND]) begin
				n.txSt = TX_MARK;
				n.txSh = 11'h7ff;
				n.txBits = 4'h1;
				n.txd = 1'b1;
			end else begin
				n = txPick(n, charLen, nine);
			end
		end

		// Receiver: start search, half-bit check, then two samples per bit.
		if (!s.c1[C1_MODULE_ON] || !s.c2[C2_RX_ON]) begin
			n.rxSt = RX_IDLE;
			n.rxCnt = 4'h0;
			n.ones = 4'h0;
		end else begin
			n.rxCnt = s.rxCnt + 4'h1;
			case (s.rxSt)
				RX_IDLE: begin
					if (!rxd) begin
						n.rxSt = RX_START;
						n.rxCnt = 4'h0;
						n.ones = 4'h0;
					end else if (s.rxCnt == BIT_LAST) begin
						n.rxCnt = 4'h0;
						if (s.ones != charLen) begin
							n.ones = s.ones + 4'h1;
						end
						if (s.ones == charLen - 4'h1) begin
							if (n.c2[C2_RX_STANDBY] && !s.c1[C1_WAKE_ADDR]) begin
								n.c2[C2_RX_STANDBY] = 1'b0;
							end else if (s.idleArm && !n.c2[C2_RX_STANDBY]) begin
								n.flags[S_QUIET] = 1'b1;
								n.idleArm = 1'b0;
							end
						end
					end
				end
				RX_START: begin
					if (s.rxCnt == HALF_LAST) begin
						n.rxCnt = 4'h0;
						n.rxBits = 4'h0;
						n.noiseHit = 1'b0;
						n.rxSt = rxd ? RX_IDLE : RX_BITS;
					end
				end
				RX_BITS: begin
					if (s.rxCnt == NOISE_AT) begin
						n.rxPrev = rxd;
					end
					if (s.rxCnt == BIT_LAST) begin
						n.rxCnt = 4'h0;
						n.noiseHit = hit;
						if (s.rxBits != charLen - 4'h2) begin
							n.rxSh = {rxd, s.rxSh[8:1]};
							n.rxBits = s.rxBits + 4'h1;
						end else begin
							n.rxSt = RX_IDLE;
							if (n.c2[C2_RX_STANDBY] && s.c1[C1_WAKE_ADDR] && msb) begin
								n.c2[C2_RX_STANDBY] = 1'b0;
							end
							if (!n.c2[C2_RX_STANDBY]) begin
								if (n.flags[S_FULL]) begin
									n.flags[S_OVERRUN] = 1'b1;
								end else begin
									n.rxData = d9[7:0];
									n.rxNinth = msb;
									n.flags[S_FULL] = 1'b1;
									n.idleArm = 1'b1;
									if (!rxd) begin
										n.flags[S_FRAMING] = 1'b1;
									end
									if (hit) begin
										n.flags[S_NOISE] = 1'b1;
									end
									if (s.c1[C1_PARITY_EN] &&
										((nine ? ^d9 : ^d9[7:0]) ^ s.c1[C1_PARITY_ODD])) begin
										n.flags[S_PARITY] = 1'b1;
									end
								end
							end
						end
					end
				end
				default: begin
					n.rxSt = RX_IDLE;
				end
			endcase
		end

		// A disabled module parks the transmitter with both transmit flags set.
		if (!n.c1[C1_MODULE_ON]) begin
			n.txSt = TX_IDLE;
			n.txd = 1'b1;
			n.pendPre = 1'b0;
			n.brkReq = 1'b0;
			n.flags[S_EMPTY] = 1'b1;
		end
		n.flags[S_DONE] = !n.c1[C1_MODULE_ON] || (n.flags[S_EMPTY] && n.txSt == TX_IDLE &&
			!n.pendPre && !n.brkReq && !(n.c2[C2_XMIT_ON] && n.c2[C2_BREAK_SEND]));

		// Requests are registered so each output leaves a flip-flop.
		n.irqTx = n.c1[C1_MODULE_ON] &&
			((n.flags[S_EMPTY] && n.c2[C2_TXBUF_IRQ_EN]) ||
			(n.flags[S_DONE] && n.c2[C2_TXDONE_IRQ_EN]));
		n.irqRx = !n.c2[C2_RX_STANDBY] &&
			((n.flags[S_FULL] && n.c2[C2_RXFULL_IRQ_EN]) ||
			(n.flags[S_QUIET] && n.c2[C2_QUIET_IRQ_EN]));
		n.irqErr = !n.c2[C2_RX_STANDBY] && (|(n.flags[3:0] & n.c3[3:0]));
	end

	// State register; the data buffers are cleared too, which software never relies on.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.c1 <= C1_RST;
			s.c2 <= C2_RST;
			s.c3 <= C3_RST;
			s.flags <= S1_RST;
			s.txSt <= TX_IDLE;
			s.rxSt <= RX_IDLE;
			s.txd <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register.
	assign apbRsp = s.rsp;
	assign txd = s.txd;
	assign irqTx = s.irqTx;
	assign irqRx = s.irqRx;
	assign irqErr = s.irqErr;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	txbuf_irq_a: assert property (s.irqTx && !s.c2[C2_TXDONE_IRQ_EN] |->
		s.flags[S_EMPTY] && s.c2[C2_TXBUF_IRQ_EN]) else $error("tx request without empty");
	txdone_irq_a: assert property (s.irqTx && !s.c2[C2_TXBUF_IRQ_EN] |->
		s.flags[S_DONE] && s.c2[C2_TXDONE_IRQ_EN]) else $error("tx request without done");
	rxfull_irq_a: assert property (s.irqRx && !s.c2[C2_QUIET_IRQ_EN] |->
		s.flags[S_FULL] && s.c2[C2_RXFULL_IRQ_EN]) else $error("rx request without full");
	standby_gate_a: assert property (s.c2[C2_RX_STANDBY] |->
		!s.irqRx && !s.irqErr) else $error("receiver request in standby");
	preamble_len_a: assert property ($rose(s.txSt == TX_PRE) |->
		s.txd && s.txBits == (nine ? 4'hb : 4'ha)) else $error("bad preamble length");
	break_low_a: assert property (s.txSt == TX_BRK |-> !s.txd)
		else $error("break bit not low");
	break_mark_a: assert property ($rose(s.txSt == TX_MARK) |->
		$past(s.txSt) == TX_BRK && s.txd) else $error("mark not after break");
	ninth_load_a: assert property ($rose(s.txSt == TX_DATA) && nine |->
		s.txSh[9] == s.c3[C3_TX_NINTH] && s.flags[S_EMPTY]) else $error("ninth bit not loaded");
	empty_clear_a: assert property ($fell(s.flags[S_EMPTY]) |->
		$past(apbAccess && apbReq.pwrite && apbReq.paddr == ADDR_DATA && s.emptyArm))
		else $error("empty cleared without sequence");
	module_off_a: assert property ($fell(s.c1[C1_MODULE_ON]) |=>
		s.flags[S_EMPTY] && s.flags[S_DONE] && !s.irqTx) else $error("module off flags");
	rx_copy_a: assert property ($rose(s.flags[S_FULL]) && !nine |->
		s.rxNinth == s.rxData[7]) else $error("ninth bit copy wrong");
endmodule

/* File: dv/asc_peer.sv */
// Remote serial node that drives the receive line and decodes the transmit line.
`timescale 1ns/1ps
module asc_peer (
	// Clock.
	input  wire logic       core_clk,
	// Serial lines.
	input  wire logic       txd,
	output logic            rxd,
	// Last decoded frame and number of frames decoded.
	output logic [9:0]      rxWord,
	output int              rxCount
);
	// The line rests high between frames, as a pulled-up line would.
	initial begin
		rxd = 1'b1;
		rxWord = '0;
		rxCount = 0;
	end

	// Sends eleven bits LSB first at 16 cycles each; short frames end in extra idle ones.
	task automatic send(input logic [10:0] bits);
		for (int i = 0; i < 11; i++) begin
			rxd <= bits[i];
			repeat (16) @(posedge core_clk);
		end
		rxd <= 1'b1;
	endtask

	// Samples the middle of ten bits after a falling start edge.
	always begin
		@(negedge txd);
		repeat (8) @(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			repeat (16) @(posedge core_clk);
			rxWord[i] = txd;
		end
		rxCount++;
	end
endmodule

/* File: dv/asc_serial_ctrl_tb.sv */
// Self-checking testbench of the serial control block against a remote serial node.
`timescale 1ns/1ps
module asc_serial_ctrl_tb
	import asc_pkg::*;
;
	logic         coreClk;
	logic         rst;
	asc_apb_req_s apbReq;
	asc_apb_rsp_s apbRsp;
	logic         rxd;
	logic         txd;
	logic         irqTx;
	logic         irqRx;
	logic         irqErr;
	logic [9:0]   rxWord;
	int           rxCount;
	int           numErrors;
	int           cmpCount;
	logic [7:0]   rdv;

	// Core clock of 40 ns period.
	always #20 coreClk = ~coreClk;

	asc_serial_ctrl u_dut (.core_clk(coreClk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
		.rxd(rxd), .txd(txd), .irqTx(irqTx), .irqRx(irqRx), .irqErr(irqErr));
	asc_peer u_peer (.core_clk(coreClk), .txd(txd), .rxd(rxd), .rxWord(rxWord),
		.rxCount(rxCount));

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request is held until the rising edge at which pready is high.
	// Pready is looked at mid-cycle, where it has settled, so that the edge does not race it.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge coreClk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, wd}};
		@(posedge coreClk);
		apbReq.penable <= 1'b1;
		do begin
			@(negedge coreClk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 20);
		rd = apbRsp.prdata[7:0];
		err = apbRsp.pslverr;
		@(posedge coreClk);
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		chk(n < 20, 1);
	endtask

	// Register write and masked register read with comparison.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		logic e;
		apb(1'b0, a, 8'h00, rdv, e);
		chk(rdv & m, exp);
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge coreClk);
	endtask

	// Waits, bounded, for the remote node to decode one more frame.
	task automatic waitFrame(input int c0);
		int n;
		n = 0;
		while (rxCount == c0 && n < 600) begin
			@(posedge coreClk);
			n++;
		end
		chk(rxCount != c0, 1);
	endtask

	// Reset values, an unmapped address, enables written while the module is off.
	task automatic t_reset();
		logic e;
		rdc(ADDR_CTRL2, 8'hff, C2_RST);
		rdc(ADDR_CTRL3, 8'hff, C3_RST);
		rdc(ADDR_STAT1, 8'hff, S1_RST);
		apb(1'b0, 8'h14, 8'h00, rdv, e);
		chk(e, 1'b1);
		wr(ADDR_CTRL2, 8'h0c);
		rdc(ADDR_CTRL2, 8'hff, 8'h00);
		$display("Test reset done");
	endtask

	// Preamble, a character finished after the transmitter is switched off, requests.
	task automatic t_tx();
		int n;
		int c0;
		n = 0;
		c0 = rxCount;
		wr(ADDR_CTRL1, 8'h40);
		wr(ADDR_CTRL2, 8'h08);
		rdc(ADDR_STAT1, 8'h80, 8'h80);
		wr(ADDR_DATA, 8'ha5);
		while (txd === 1'b1 && n < 300) begin
			@(posedge coreClk);
			n++;
		end
		chk(n >= 140 && n <= 200, 1);
		wr(ADDR_CTRL2, 8'h00);
		rdc(ADDR_STAT1, 8'hc0, 8'h80);
		waitFrame(c0);
		chk(rxWord[8:0], 9'h1a5);
		ticks(32);
		rdc(ADDR_STAT1, 8'hc0, 8'hc0);
		wr(ADDR_CTRL2, 8'h80);
		ticks(2);
		chk(irqTx, 1'b1);
		wr(ADDR_CTRL2, 8'h40);
		ticks(2);
		chk(irqTx, 1'b1);
		wr(ADDR_CTRL2, 8'h00);
		ticks(2);
		chk(irqTx, 1'b0);
		$display("Test transmit done");
	endtask

	// Nine-bit characters in both directions.
	task automatic t_nine();
		int c0;
		c0 = rxCount;
		wr(ADDR_CTRL1, 8'h50);
		wr(ADDR_CTRL3, 8'h40);
		wr(ADDR_CTRL2, 8'h0c);
		rdc(ADDR_STAT1, 8'h80, 8'h80);
		wr(ADDR_DATA, 8'h3c);
		waitFrame(c0);
		chk(rxWord, 10'h33c);
		u_peer.send({1'b1, 1'b1, 8'h12, 1'b0});
		rdc(ADDR_CTRL3, 8'h80, 8'h80);
		rdc(ADDR_STAT1, 8'h20, 8'h20);
		rdc(ADDR_DATA, 8'hff, 8'h12);
		$display("Test nine-bit done");
	endtask

	// Eight-bit reception, receiver disable, quiet line request.
	task automatic t_rx();
		wr(ADDR_CTRL1, 8'h40);
		wr(ADDR_CTRL2, 8'h24);
		u_peer.send({2'b11, 8'h81, 1'b0});
		ticks(4);
		chk(irqRx, 1'b1);
		wr(ADDR_CTRL2, 8'h20);
		ticks(2);
		chk(irqRx, 1'b1);
		rdc(ADDR_CTRL3, 8'h80, 8'h80);
		rdc(ADDR_STAT1, 8'h20, 8'h20);
		rdc(ADDR_DATA, 8'hff, 8'h81);
		ticks(2);
		chk(irqRx, 1'b0);
		wr(ADDR_CTRL2, 8'h14);
		ticks(220);
		chk(irqRx, 1'b1);
		wr(ADDR_CTRL2, 8'h04);
		ticks(2);
		chk(irqRx, 1'b0);
		rdc(ADDR_STAT1, 8'h10, 8'h10);
		rdc(ADDR_DATA, 8'h00, 8'h00);
		$display("Test receive done");
	endtask

	// Parity error and overrun, each gated by its own enable.
	task automatic t_err();
		wr(ADDR_CTRL1, 8'h42);
		wr(ADDR_CTRL3, 8'h01);
		u_peer.send({2'b11, 8'h01, 1'b0});
		ticks(4);
		chk(irqErr, 1'b1);
		wr(ADDR_CTRL3, 8'h08);
		ticks(2);
		chk(irqErr, 1'b0);
		u_peer.send({2'b11, 8'h81, 1'b0});
		ticks(4);
		chk(irqErr, 1'b1);
		rdc(ADDR_STAT1, 8'h29, 8'h29);
		rdc(ADDR_DATA, 8'hff, 8'h01);
		$display("Test errors done");
	endtask

	// Standby hides a character; an address mark ends standby.
	task automatic t_standby();
		wr(ADDR_CTRL1, 8'h48);
		wr(ADDR_CTRL2, 8'h26);
		u_peer.send({2'b11, 8'h05, 1'b0});
		ticks(4);
		chk(irqRx, 1'b0);
		rdc(ADDR_STAT1, 8'h20, 8'h00);
		u_peer.send({2'b11, 8'h85, 1'b0});
		ticks(4);
		rdc(ADDR_CTRL2, 8'h02, 8'h00);
		rdc(ADDR_STAT1, 8'h00, 8'h00);
		rdc(ADDR_DATA, 8'h00, 8'h00);
		$display("Test standby done");
	endtask

	// Held break replaces the preamble and runs without gaps; release returns high.
	task automatic t_break();
		int highs;
		highs = 0;
		wr(ADDR_CTRL1, 8'h40);
		wr(ADDR_CTRL2, 8'h09);
		ticks(40);
		repeat (320) begin
			@(posedge coreClk);
			highs += (txd !== 1'b0);
		end
		chk(highs, 0);
		wr(ADDR_CTRL2, 8'h08);
		ticks(240);
		chk(txd, 1'b1);
		$display("Test break done");
	endtask

	// Empty cleared by the status-then-data sequence; module off sets flags, blocks transmit requests.
	task automatic t_off();
		wr(ADDR_CTRL2, 8'hc0);
		rdc(ADDR_STAT1, 8'h80, 8'h80);
		wr(ADDR_DATA, 8'h5a);
		rdc(ADDR_STAT1, 8'hc0, 8'h00);
		chk(irqTx, 1'b0);
		wr(ADDR_CTRL1, 8'h00);
		ticks(2);
		chk(irqTx, 1'b0);
		rdc(ADDR_STAT1, 8'hc0, 8'hc0);
		$display("Test module off done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		coreClk = 1'b0;
		rst = 1'b1;
		apbReq = '0;
		numErrors = 0;
		cmpCount = 0;
		repeat (8) @(posedge coreClk);
		rst <= 1'b0;
		t_reset();
		t_tx();
		t_nine();
		t_rx();
		t_err();
		t_standby();
		t_break();
		t_off();
		results();
	end

	// Watchdog: the whole sequence needs well under a third of this span.
	initial begin
		repeat (20000) @(posedge coreClk);
		numErrors++;
		results();
	end
endmodule
